// ==== src/scg_strip_clock_generator.sv ====
// strip clock generator: readout clocks, crossing clock synthesizer, crossing counter, registers
//
// What this block does
// - crossing clock source is the main oscillator, or external input when control bit 16 set.
// - selected source feeds a synthesizer with programmable multiply and divide; 12/5 after reset.
// - fast synthesized ticks split each crossing period into eight fine time bins.
// - control bit 17 makes crossing period four fast ticks, giving four bins.
// - readout master clocks A and B both come from the main oscillator.
// - a double-rate capture strobe is phase aligned to readout master clock A.
// - a 200 MHz injection phase is synthesized from the main oscillator.
// - converter serial interfaces are ticked from the 5 MHz oscillator.
// - numerator and denominator factors scale the source frequency.
// - 48-bit crossing counter, read and written as low 32 and upper 16 words.
// - config write with top bit set writes data; clear requests read; top bit shows busy.
// - control bit 31 resets the synthesizer; bits 30 and 29 report lock.
// - control bit 19 enables counting; bit 22 holds the counter at zero.
`timescale 1ns/1ps
module scg_strip_clock_generator
  import scg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_osc_main,
  input wire logic i_osc_slow,
  input wire logic i_ext_clk,
  input wire logic [31:0] i_bus_addr,
  input wire logic i_bus_wr,
  input wire logic i_bus_rd,
  input wire logic [31:0] i_bus_wdata,
  output logic [31:0] o_bus_rdata,
  output logic o_bus_ready,
  output logic o_mclk_a,
  output logic o_mclk_b,
  output logic o_ddr_capture,
  output logic [7:0] o_inject_phase,
  output logic o_spi_tick,
  output logic o_bin_tick,
  output logic [2:0] o_fine_bin,
  output logic o_crossing_tick,
  output logic o_bunch_crossing_clock
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling: two flops, then a third for edge detection
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] sync1;
  logic [PIN_COUNT-1:0] sync2;
  logic [PIN_COUNT-1:0] sync3;
  logic [PIN_COUNT-1:0] rise;

  assign pin_raw = {i_ext_clk, i_osc_slow, i_osc_main};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      assign rise[gi] = sync2[gi] & ~sync3[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0] control_status;
  logic [COUNT_W-1:0] crossing_count;
  logic [FACTOR_W-1:0] num_m1;
  logic [FACTOR_W-1:0] den_m1;
  logic synth_busy;
  logic synth_go;
  logic [SY_ADDR_W-1:0] synth_addr;
  logic [SY_DATA_W-1:0] synth_wdata;
  logic [SY_DATA_W-1:0] synth_rdata;
  logic [3:0] synth_cnt;
  logic mclk_locked;
  logic xing_locked;
  logic [4:0] mclk_lock_cnt;
  logic [4:0] xing_lock_cnt;

  logic synth_reset;
  logic ext_sel;
  logic quad_sel;
  assign synth_reset = control_status[CS_SYNTH_RESET];
  assign ext_sel = control_status[CS_EXT_SOURCE];
  assign quad_sel = control_status[CS_QUAD_RATE];

  logic hit_cs;
  logic hit_low;
  logic hit_high;
  logic hit_synth;
  logic bus_hit;
  assign hit_cs = (i_bus_addr == ADDR_CONTROL_STATUS);
  assign hit_low = (i_bus_addr == ADDR_COUNT_LOW);
  assign hit_high = (i_bus_addr == ADDR_COUNT_HIGH);
  assign hit_synth = (i_bus_addr == ADDR_SYNTH_CONFIG);
  assign bus_hit = hit_cs | hit_low | hit_high | hit_synth;

  logic synth_accept;
  assign synth_accept = i_bus_wr & hit_synth & ~synth_busy;

  ////////////////////////////////////////////////////////////////////////////
  // register bus: access taken on the edge, ready and data one cycle later
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      control_status <= CS_RESET;
    end else if (i_bus_wr && hit_cs) begin
      control_status <= i_bus_wdata & CS_WRITE_MASK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_bus_ready <= 1'b0;
      o_bus_rdata <= 32'h0000_0000;
    end else begin
      o_bus_ready <= (i_bus_wr | i_bus_rd) & bus_hit;
      o_bus_rdata <= 32'h0000_0000;
      if (i_bus_rd) begin
        if (hit_cs) begin
          o_bus_rdata <= control_status;
          o_bus_rdata[CS_MCLK_LOCKED] <= mclk_locked;
          o_bus_rdata[CS_XING_LOCKED] <= xing_locked;
        end else if (hit_low) begin
          o_bus_rdata <= crossing_count[31:0];
        end else if (hit_high) begin
          o_bus_rdata <= {16'h0000, crossing_count[COUNT_W-1:32]};
        end else if (hit_synth) begin
          o_bus_rdata <= {synth_busy, 8'h00, synth_addr, synth_rdata};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synthesizer configuration port; a write while busy is dropped
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      synth_busy <= 1'b0;
      synth_go <= 1'b0;
      synth_addr <= 7'h00;
      synth_wdata <= 16'h0000;
      synth_rdata <= 16'h0000;
      synth_cnt <= 4'h0;
      num_m1 <= NUM_M1_RESET;
      den_m1 <= DEN_M1_RESET;
    end else if (synth_accept) begin
      synth_busy <= 1'b1;
      synth_go <= i_bus_wdata[SY_GO];
      synth_addr <= i_bus_wdata[SY_ADDR_HI:SY_ADDR_LO];
      synth_wdata <= i_bus_wdata[SY_DATA_W-1:0];
      synth_cnt <= 4'(SYNTH_ACCESS_CYCLES);
    end else if (synth_busy) begin
      synth_cnt <= synth_cnt - 4'h1;
      if (synth_cnt == 4'h1) begin
        synth_busy <= 1'b0;
        if (synth_go) begin
          if (synth_addr == SYNTH_NUM_ADDR) num_m1 <= synth_wdata[FACTOR_W-1:0];
          if (synth_addr == SYNTH_DEN_ADDR) den_m1 <= synth_wdata[FACTOR_W-1:0];
        end else begin
          synth_rdata <= 16'h0000;
          if (synth_addr == SYNTH_NUM_ADDR) synth_rdata <= {11'h000, num_m1};
          if (synth_addr == SYNTH_DEN_ADDR) synth_rdata <= {11'h000, den_m1};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fractional synthesizer: N/D ticks per source edge, at most one per cycle,
  // so a fast clock above the system rate saturates rather than wraps
  logic src_tick;
  logic [8:0] next_sum;
  logic next_fast;
  logic [7:0] acc;

  assign src_tick = ext_sel ? rise[PIN_EXT] : rise[PIN_MAIN];

  always_comb begin
    next_sum = {1'b0, acc} + (src_tick ? {3'b000, 1'b0, num_m1} + 9'h001 : 9'h000);
    next_fast = 1'b0;
    if (next_sum >= {3'b000, 1'b0, den_m1} + 9'h001) begin
      next_sum = next_sum - ({3'b000, 1'b0, den_m1} + 9'h001);
      next_fast = 1'b1;
    end
    if (next_sum[8]) next_sum = 9'h0ff;
  end

  logic [2:0] last_bin;
  logic [2:0] half_bin;
  logic [2:0] next_bin;
  assign last_bin = quad_sel ? LAST_BIN_QUAD : LAST_BIN_NORMAL;
  assign half_bin = quad_sel ? HALF_BIN_QUAD : HALF_BIN_NORMAL;
  assign next_bin = (o_fine_bin >= last_bin) ? 3'h0 : o_fine_bin + 3'h1;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || synth_reset) begin
      acc <= 8'h00;
      o_bin_tick <= 1'b0;
      o_fine_bin <= 3'h0;
      o_crossing_tick <= 1'b0;
      o_bunch_crossing_clock <= 1'b0;
    end else begin
      acc <= next_sum[7:0];
      o_bin_tick <= next_fast;
      o_crossing_tick <= next_fast && (next_bin == 3'h0);
      if (next_fast) begin
        o_fine_bin <= next_bin;
        o_bunch_crossing_clock <= (next_bin < half_bin);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock status: a fixed number of edges after reset; crossing lock also restarts on any change of settings
  logic settings_change;
  assign settings_change = (synth_busy && synth_cnt == 4'h1 && synth_go) ||
                           (i_bus_wr && hit_cs &&
                            i_bus_wdata[CS_QUAD_RATE:CS_EXT_SOURCE] != control_status[CS_QUAD_RATE:CS_EXT_SOURCE]);

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || synth_reset) begin
      mclk_lock_cnt <= 5'h00;
      mclk_locked <= 1'b0;
    end else if (rise[PIN_MAIN] && !mclk_locked) begin
      mclk_lock_cnt <= mclk_lock_cnt + 5'h01;
      mclk_locked <= (mclk_lock_cnt + 5'h01 == LOCK_EDGES);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || synth_reset || settings_change) begin
      xing_lock_cnt <= 5'h00;
      xing_locked <= 1'b0;
    end else if (o_bin_tick && !xing_locked) begin
      xing_lock_cnt <= xing_lock_cnt + 5'h01;
      xing_locked <= (xing_lock_cnt + 5'h01 == LOCK_EDGES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readout clocks, capture strobe, injection phase, serial tick
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_mclk_a <= 1'b0;
      o_mclk_b <= 1'b0;
      o_ddr_capture <= 1'b0;
      o_inject_phase <= 8'h00;
      o_spi_tick <= 1'b0;
    end else begin
      o_ddr_capture <= rise[PIN_MAIN];
      o_spi_tick <= rise[PIN_SLOW];
      if (rise[PIN_MAIN]) begin
        o_mclk_a <= ~o_mclk_a;
        o_mclk_b <= ~o_mclk_a;
        o_inject_phase <= o_inject_phase + INJECT_STEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossing counter: clear beats a bus write, a write beats counting
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || control_status[CS_COUNT_CLEAR]) begin
      crossing_count <= 48'h0000_0000_0000;
    end else if (i_bus_wr && hit_low) begin
      crossing_count[31:0] <= i_bus_wdata;
    end else if (i_bus_wr && hit_high) begin
      crossing_count[COUNT_W-1:32] <= i_bus_wdata[15:0];
    end else if (control_status[CS_COUNT_ENABLE] && o_crossing_tick) begin
      crossing_count <= crossing_count + 48'h0000_0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_port_busy;
    synth_busy [*4] ##1 !synth_busy;
  endsequence

  chk_synth_busy: assert property (synth_accept |=> s_port_busy)
    else $error("config port busy time wrong");
  chk_num_write: assert property (synth_accept && i_bus_wdata[SY_GO] &&
      i_bus_wdata[SY_ADDR_HI:SY_ADDR_LO] == SYNTH_NUM_ADDR |-> ##5 num_m1 == $past(i_bus_wdata[4:0], 5))
    else $error("numerator not written");
  chk_bus_ready: assert property ((i_bus_wr || i_bus_rd) |=> o_bus_ready == $past(bus_hit))
    else $error("bus ready wrong");
  chk_count_clear: assert property (control_status[CS_COUNT_CLEAR] |=> crossing_count == 48'h0000_0000_0000)
    else $error("counter not cleared");
  chk_count_incr: assert property (control_status[CS_COUNT_ENABLE] && !control_status[CS_COUNT_CLEAR] &&
      o_crossing_tick && !i_bus_wr |=> crossing_count == $past(crossing_count) + 48'h0000_0000_0001)
    else $error("counter did not increment");
  chk_quad_bins: assert property (quad_sel && $past(quad_sel) && $past(o_bin_tick) |-> o_fine_bin < 3'h4)
    else $error("quad rate bin out of range");
  chk_bin_wrap: assert property (o_bin_tick && o_fine_bin == 3'h0 |-> o_crossing_tick)
    else $error("crossing tick missing at bin zero");
  chk_synth_reset: assert property (synth_reset |=> !o_bin_tick && !xing_locked && !mclk_locked)
    else $error("synthesizer reset ignored");
  chk_mclk_toggle: assert property (rise[PIN_MAIN] |=> o_mclk_a != $past(o_mclk_a) && o_ddr_capture)
    else $error("readout clock did not follow oscillator");
  chk_spi_tick: assert property (rise[PIN_SLOW] |=> o_spi_tick)
    else $error("serial tick missing");

endmodule

// ==== inc/scg_pkg.sv ====
// constants shared by the strip clock generator: register map, field positions, timing
package scg_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_CONTROL_STATUS = 32'hc400_0000;
  localparam logic [31:0] ADDR_COUNT_LOW = 32'hc400_0040;
  localparam logic [31:0] ADDR_COUNT_HIGH = 32'hc400_0044;
  localparam logic [31:0] ADDR_SYNTH_CONFIG = 32'hc400_0048;

  // strip_control_status fields
  localparam int CS_SYNTH_RESET = 31;
  localparam int CS_MCLK_LOCKED = 30;
  localparam int CS_XING_LOCKED = 29;
  localparam int CS_COUNT_CLEAR = 22;
  localparam int CS_COUNT_ENABLE = 19;
  localparam int CS_QUAD_RATE = 17;
  localparam int CS_EXT_SOURCE = 16;
  localparam logic [31:0] CS_WRITE_MASK = 32'h804b_0000;
  localparam logic [31:0] CS_RESET = 32'h0000_0000;

  // synth_config_port fields
  localparam int SY_GO = 31;
  localparam int SY_ADDR_HI = 22;
  localparam int SY_ADDR_LO = 16;
  localparam int SY_DATA_W = 16;
  localparam int SY_ADDR_W = 7;
  localparam logic [6:0] SYNTH_NUM_ADDR = 7'h50;
  localparam logic [6:0] SYNTH_DEN_ADDR = 7'h52;
  localparam int FACTOR_W = 5;
  localparam logic [4:0] NUM_M1_RESET = 5'h0b;
  localparam logic [4:0] DEN_M1_RESET = 5'h04;

  // fine time bins per crossing period
  localparam logic [2:0] LAST_BIN_NORMAL = 3'h7;
  localparam logic [2:0] LAST_BIN_QUAD = 3'h3;
  localparam logic [2:0] HALF_BIN_NORMAL = 3'h4;
  localparam logic [2:0] HALF_BIN_QUAD = 3'h2;

  // pin indices of the sampled oscillator inputs
  localparam int PIN_MAIN = 0;
  localparam int PIN_SLOW = 1;
  localparam int PIN_EXT = 2;
  localparam int PIN_COUNT = 3;

  // 200 MHz phase advance per 66.667 MHz edge
  localparam logic [7:0] INJECT_STEP = 8'h03;

  // timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SYNTH_ACCESS_NS = 100;
  localparam int SYNTH_ACCESS_CYCLES = (SYNTH_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0] LOCK_EDGES = 5'h10;
  localparam int COUNT_W = 48;

endpackage

// ==== tb/scg_readout_model.sv ====
// readout-side model: oscillator sources and a watcher on the clocks sent to the chips
`timescale 1ns/1ps
module scg_readout_model #(
  parameter real EXT_HALF_NS = 35.0
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_mclk_a,
  input wire logic i_mclk_b,
  input wire logic i_ddr_capture,
  input wire logic [7:0] i_inject_phase,
  output logic o_osc_main,
  output logic o_osc_slow,
  output logic o_ext_clk,
  output logic [15:0] o_faults,
  output logic [15:0] o_ddr_count
);
  logic last_a;
  logic [7:0] last_phase;
  logic bad_b, bad_ddr, bad_ph;
  initial begin
    o_osc_main = 1'b0;
    o_osc_slow = 1'b0;
    o_ext_clk = 1'b0;
    o_faults = 16'h0000;
    o_ddr_count = 16'h0000;
  end
  always #7.5 o_osc_main = ~o_osc_main;
  always #100 o_osc_slow = ~o_osc_slow;
  // external source kept slower than the system clock so its edges survive sampling
  initial begin
    #3.1;
    forever #(EXT_HALF_NS) o_ext_clk = ~o_ext_clk;
  end
  assign bad_b = (i_mclk_b !== i_mclk_a);
  assign bad_ddr = (i_ddr_capture === 1'b1) && (i_mclk_a === last_a);
  assign bad_ph = (i_inject_phase !== last_phase) && (i_inject_phase !== last_phase + 8'h03);
  always @(posedge i_sys_clk) begin
    last_a <= i_mclk_a;
    last_phase <= i_inject_phase;
    if (i_resetn === 1'b1 && last_phase !== 8'hxx) begin
      o_faults <= o_faults + 16'(bad_b) + 16'(bad_ddr) + 16'(bad_ph);
      o_ddr_count <= o_ddr_count + 16'(i_ddr_capture === 1'b1);
    end
  end
endmodule

// ==== tb/scg_strip_clock_generator_tb.sv ====
// self-checking bench for the strip clock generator
`timescale 1ns/1ps
module scg_strip_clock_generator_tb;
  import scg_pkg::*;
  logic i_sys_clk, i_resetn, osc_main, osc_slow, ext_clk, i_bus_wr, i_bus_rd, o_bus_ready, ok;
  logic [31:0] i_bus_addr, i_bus_wdata, o_bus_rdata, q;
  logic o_mclk_a, o_mclk_b, o_ddr_capture, o_spi_tick, o_bin_tick, o_crossing_tick, o_xclk;
  logic [7:0] o_inject_phase;
  logic [2:0] o_fine_bin;
  logic [15:0] faults, ddr_count;
  logic [47:0] total;
  logic quad_mode = 1'b0;
  int err_total = 0, compares = 0, cycles = 0, run = 0, span = 0, xings = 0, spis = 0, x0, s0;

  scg_strip_clock_generator scg_strip_clock_generator_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_osc_main(osc_main), .i_osc_slow(osc_slow), .i_ext_clk(ext_clk), .i_bus_addr(i_bus_addr),
    .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
    .o_bus_ready(o_bus_ready), .o_mclk_a(o_mclk_a), .o_mclk_b(o_mclk_b), .o_ddr_capture(o_ddr_capture),
    .o_inject_phase(o_inject_phase), .o_spi_tick(o_spi_tick), .o_bin_tick(o_bin_tick),
    .o_fine_bin(o_fine_bin), .o_crossing_tick(o_crossing_tick), .o_bunch_crossing_clock(o_xclk));
  scg_readout_model scg_readout_model_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_mclk_a(o_mclk_a),
    .i_mclk_b(o_mclk_b), .i_ddr_capture(o_ddr_capture), .i_inject_phase(o_inject_phase),
    .o_osc_main(osc_main), .o_osc_slow(osc_slow), .o_ext_clk(ext_clk), .o_faults(faults),
    .o_ddr_count(ddr_count));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // span counts fast ticks from one crossing to the next, the crossing tick included
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (o_spi_tick === 1'b1) spis <= spis + 1;
    if (o_crossing_tick === 1'b1) begin
      span <= run;
      run <= 1;
      xings <= xings + 1;
    end else if (o_bin_tick === 1'b1) begin
      run <= run + 1;
    end
    if (o_crossing_tick === 1'b1) begin
      chk("crossing bin", 32'h0000_0000, 32'(o_fine_bin));
      chk("crossing clock high", 32'h0000_0001, 32'(o_xclk));
    end
    // the crossing clock drops at the middle bin of the period
    if (o_bin_tick === 1'b1 && o_fine_bin === (quad_mode ? 3'h2 : 3'h4)) begin
      chk("crossing clock low", 32'h0000_0000, 32'(o_xclk));
    end
    if (cycles == 6000) begin
      err_total++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle strobe, then up to three cycles for the acknowledge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    ok = 1'b0;
    i_bus_wr = wr;
    i_bus_rd = !wr;
    i_bus_addr = a;
    i_bus_wdata = d;
    @(negedge i_sys_clk);
    i_bus_wr = 1'b0;
    i_bus_rd = 1'b0;
    for (int k = 0; k < 3 && !ok; k++) begin
      if (o_bus_ready === 1'b1) begin
        ok = 1'b1;
        q = o_bus_rdata;
      end else begin
        @(negedge i_sys_clk);
      end
    end
    // spare cycle so a following call never drives the strobes twice in one step
    @(negedge i_sys_clk);
  endtask

  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    chk("write ack", 32'h0000_0001, 32'(ok));
  endtask

  task automatic rreg(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, ok ? q : 32'hxxxx_xxxx);
  endtask

  // the config port drops writes while busy, so this polls the busy bit until it clears
  task automatic idle_wait;
    for (int k = 0; k < 10; k++) begin
      bus(1'b0, ADDR_SYNTH_CONFIG, 32'h0000_0000);
      if (q[31] === 1'b0) break;
    end
    chk("config idle", 32'h0000_0000, 32'(q[31]));
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_resetn = 1'b0;
    i_bus_wr = 1'b0;
    i_bus_rd = 1'b0;
    i_bus_addr = 32'h0000_0000;
    i_bus_wdata = 32'h0000_0000;
    repeat (12) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    rreg("control reset", ADDR_CONTROL_STATUS, 32'h0000_0000);
    rreg("count low reset", ADDR_COUNT_LOW, 32'h0000_0000);
    rreg("count high reset", ADDR_COUNT_HIGH, 32'h0000_0000);
    bus(1'b0, 32'hc400_004c, 32'h0000_0000);
    chk("unmapped ack", 32'h0000_0000, 32'(ok));
    $display("test reset done");
    wreg(ADDR_CONTROL_STATUS, 32'hffff_ffff);
    rreg("control mask", ADDR_CONTROL_STATUS, 32'h804b_0000);
    wreg(ADDR_COUNT_LOW, 32'h0000_0005);
    rreg("count held clear", ADDR_COUNT_LOW, 32'h0000_0000);
    wreg(ADDR_CONTROL_STATUS, 32'h8000_0000);
    wreg(ADDR_COUNT_LOW, 32'hffff_fff0);
    wreg(ADDR_COUNT_HIGH, 32'hffff_ffff);
    rreg("count high width", ADDR_COUNT_HIGH, 32'h0000_ffff);
    rreg("count low", ADDR_COUNT_LOW, 32'hffff_fff0);
    wreg(ADDR_COUNT_HIGH, 32'h0000_0000);
    $display("test registers done");
    wreg(ADDR_SYNTH_CONFIG, 32'h8050_000b);
    bus(1'b0, ADDR_SYNTH_CONFIG, 32'h0000_0000);
    chk("config busy", 32'h0000_0001, 32'(q[31]));
    // taken on the last busy edge, so it must be dropped; the numerator check below sees it
    wreg(ADDR_SYNTH_CONFIG, 32'h8050_001f);
    idle_wait();
    wreg(ADDR_SYNTH_CONFIG, 32'h8052_0004);
    idle_wait();
    wreg(ADDR_SYNTH_CONFIG, 32'h0052_0000);
    idle_wait();
    chk("denominator", 32'h0052_0004, q);
    wreg(ADDR_SYNTH_CONFIG, 32'h0050_0000);
    idle_wait();
    chk("numerator", 32'h0050_000b, q);
    $display("test synthesizer port done");
    wreg(ADDR_CONTROL_STATUS, 32'h8008_0000);
    x0 = xings;
    s0 = spis;
    wreg(ADDR_CONTROL_STATUS, 32'h0008_0000);
    repeat (600) @(negedge i_sys_clk);
    rreg("locks", ADDR_CONTROL_STATUS, 32'h6008_0000);
    chk("spi ticks", 32'h0000_0001, 32'(spis - s0 > 73 && spis - s0 < 78));
    chk("bins per crossing", 32'h0000_0008, span);
    wreg(ADDR_CONTROL_STATUS, 32'h8008_0000);
    repeat (4) @(negedge i_sys_clk);
    total = 48'h0000_ffff_fff0 + 48'(xings - x0);
    chk("carry reached", 32'h0000_0001, 32'(xings - x0 > 16));
    rreg("count low run", ADDR_COUNT_LOW, total[31:0]);
    rreg("count high run", ADDR_COUNT_HIGH, {16'h0000, total[47:32]});
    $display("test counter done");
    quad_mode = 1'b1;
    wreg(ADDR_CONTROL_STATUS, 32'h0003_0000);
    x0 = xings;
    repeat (300) @(negedge i_sys_clk);
    chk("bins per crossing quad", 32'h0000_0004, span);
    chk("external source runs", 32'h0000_0001, 32'(xings - x0 > 4));
    chk("readout clocks", 32'h0000_0000, 32'(faults));
    chk("capture pulses", 32'h0000_0001, 32'(ddr_count > 16'h0010));
    $display("test clocks done");
    stop_test();
  end
endmodule
